// ===== core/phyc_regs.sv
`timescale 1ns/10ps
`include "phyc_params.svh"

// What this block does
// - address bits 15:14 select this register
// - bit 13 picks general-purpose or own feedback
// - bit 12 set means read without storing
// - bit 11 keeps CAN supply on off-line
// - bit 10 listen mode, auto-cleared entering on-line/active
// - bit 9 long/short timeout, extended after wake
// - off-line only after selected bus-idle time
// - bit 8 or interface failure disables transmitter
// - failure recovers on good traffic or toggle
// - loopback transmit to receive when bits 7,8
// - bit 6 active only in normal/flash
// - bit 5 drives common-mode output, else floating
// - bit 4 LIN active only in normal/flash
// - bit 3 selects low LIN slope
// - bit 2 selects strong LIN drive
// - bit 1 enables LIN bus wake-up
// - bit 0 disables LIN transmitter
// - settings held and read back as feedback

module phyc_regs
    import phyc_pkg::*;
#(
    parameter logic [`PHYC_TMR_W-1:0] OFF_SHORT_CYC =
        `PHYC_TMR_W'(`PHYC_OFF_SHORT_CYC),
    parameter logic [`PHYC_TMR_W-1:0] OFF_LONG_CYC =
        `PHYC_TMR_W'(`PHYC_OFF_LONG_CYC),
    parameter logic [`PHYC_TMR_W-1:0] OFF_EXT_CYC =
        `PHYC_TMR_W'(`PHYC_OFF_EXT_CYC)
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control word from the serial interface
    input wire logic ctl_word_valid,
    input wire logic [`PHYC_WORD_W-1:0] ctl_word,
    input wire logic [`PHYC_WORD_W-1:0] gp1_feedback,
    output logic readback_valid,
    output logic [`PHYC_WORD_W-1:0] readback_word,
    // chip-level state
    input wire logic chip_normal_or_flash,
    input wire logic wakeup_event,
    // CAN controller side
    input wire logic can_transmit_pin,
    output logic can_receive_pin,
    // CAN transceiver side
    input wire logic can_bus_rx,
    input wire logic can_bus_activity,
    input wire logic can_if_fail,
    input wire logic can_good_traffic,
    output logic can_bus_tx,
    output logic can_tx_enable,
    output phyc_can_mode_t can_mode,
    output logic can_supply_regulator_on,
    output logic can_common_mode_oe_n,
    // LIN transceiver side
    input wire logic lin_bus_wake,
    input wire logic lin_if_fail,
    input wire logic lin_good_traffic,
    output logic lin_active,
    output logic lin_tx_enable,
    output logic lin_low_slope,
    output logic lin_strong_drive,
    output logic lin_wake_event
);

    ////////////////////////////////////////////////////////////////////////
    // state

    phyc_state_t st_r;
    phyc_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // control word decode

    logic word_hit;
    logic word_store;
    logic word_rdsel;
    logic [`PHYC_CFG_W-1:0] word_cfg;
    logic [`PHYC_WORD_W-1:0] own_feedback;

    assign word_hit = ctl_word_valid &&
        (ctl_word[`PHYC_ADDR_HI:`PHYC_ADDR_LO] == `PHYC_ADDR_PHY);
    assign word_store = word_hit && !ctl_word[`PHYC_BIT_NOWRITE];
    assign word_rdsel = ctl_word[`PHYC_BIT_RDSEL];
    assign word_cfg = ctl_word[`PHYC_CFG_W-1:0];

    // feedback carries the address and the settings in force
    assign own_feedback = {`PHYC_ADDR_PHY, `PHYC_FB_FLAGS, st_r.cfg};

    ////////////////////////////////////////////////////////////////////////
    // configuration fields

    logic cfg_supply_keep;
    logic cfg_listen;
    logic cfg_tout_long;
    logic cfg_can_txoff;
    logic cfg_loop;
    logic cfg_can_act;
    logic cfg_common_mode;
    logic cfg_lin_act;
    logic cfg_lin_slope;
    logic cfg_lin_drive;
    logic cfg_lin_wake;
    logic cfg_lin_txoff;

    assign cfg_supply_keep = st_r.cfg[`PHYC_BIT_SUPPLY_KEEP];
    assign cfg_listen = st_r.cfg[`PHYC_BIT_LISTEN];
    assign cfg_tout_long = st_r.cfg[`PHYC_BIT_TOUT_LONG];
    assign cfg_can_txoff = st_r.cfg[`PHYC_BIT_CAN_TXOFF];
    assign cfg_loop = st_r.cfg[`PHYC_BIT_LOOP];
    assign cfg_can_act = st_r.cfg[`PHYC_BIT_CAN_ACT];
    assign cfg_common_mode = st_r.cfg[`PHYC_BIT_COMMON_MODE];
    assign cfg_lin_act = st_r.cfg[`PHYC_BIT_LIN_ACT];
    assign cfg_lin_slope = st_r.cfg[`PHYC_BIT_LIN_SLOPE];
    assign cfg_lin_drive = st_r.cfg[`PHYC_BIT_LIN_DRIVE];
    assign cfg_lin_wake = st_r.cfg[`PHYC_BIT_LIN_WAKE];
    assign cfg_lin_txoff = st_r.cfg[`PHYC_BIT_LIN_TXOFF];

    ////////////////////////////////////////////////////////////////////////
    // off-line timeout

    logic idle_run;
    logic idle_expired;
    logic [`PHYC_TMR_W-1:0] idle_limit;

    // a wake-up stretches the first idle window whatever bit 9 says
    always_comb begin
        if (st_r.ext) begin
            idle_limit = OFF_EXT_CYC;
        end else if (cfg_tout_long) begin
            idle_limit = OFF_LONG_CYC;
        end else begin
            idle_limit = OFF_SHORT_CYC;
        end
    end

    // any bus activity restarts the idle count
    assign idle_run = ((st_r.mode == CAN_ONLINE) ||
        (st_r.mode == CAN_LISTEN)) && !can_bus_activity;

    phyc_idle_timer u_idle_timer (
        .clk(clk),
        .rst_n(rst_n),
        .run(idle_run),
        .limit(idle_limit),
        .expired(idle_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // interface failure guards

    logic can_failed;
    logic lin_failed;

    phyc_tx_guard u_can_guard (
        .clk(clk),
        .rst_n(rst_n),
        .fail_event(can_if_fail),
        .good_traffic(can_good_traffic),
        .sw_disable(cfg_can_txoff),
        .failed(can_failed)
    );

    phyc_tx_guard u_lin_guard (
        .clk(clk),
        .rst_n(rst_n),
        .fail_event(lin_if_fail),
        .good_traffic(lin_good_traffic),
        .sw_disable(cfg_lin_txoff),
        .failed(lin_failed)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic can_act_ok;
    logic lin_act_ok;
    logic [`PHYC_CFG_W-1:0] cfg_work;
    phyc_can_mode_t mode_nxt;
    phyc_can_mode_t mode_awake;

    assign can_act_ok = cfg_can_act && chip_normal_or_flash;
    assign lin_act_ok = cfg_lin_act && chip_normal_or_flash;

    // where the transceiver goes on bus activity or on leaving active
    always_comb begin
        if (cfg_listen) begin
            mode_awake = CAN_LISTEN;
        end else begin
            mode_awake = CAN_ONLINE;
        end
    end

    always_comb begin
        mode_nxt = st_r.mode;
        unique case (st_r.mode)
            CAN_OFFLINE: begin
                if (can_act_ok) begin
                    mode_nxt = CAN_ACTIVE;
                end else if (can_bus_activity) begin
                    mode_nxt = mode_awake;
                end
            end
            CAN_ONLINE: begin
                if (can_act_ok) begin
                    mode_nxt = CAN_ACTIVE;
                end else if (idle_expired) begin
                    mode_nxt = CAN_OFFLINE;
                end else if (cfg_listen) begin
                    mode_nxt = CAN_LISTEN;
                end
            end
            CAN_LISTEN: begin
                if (can_act_ok) begin
                    mode_nxt = CAN_ACTIVE;
                end else if (idle_expired) begin
                    mode_nxt = CAN_OFFLINE;
                end else if (!cfg_listen) begin
                    mode_nxt = CAN_ONLINE;
                end
            end
            CAN_ACTIVE: begin
                if (!can_act_ok) begin
                    mode_nxt = mode_awake;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // derived controls

    logic listen_clear;
    logic loop_on;
    logic can_tx_ok;
    logic supply_need;
    logic lin_tx_ok;
    logic lin_wake_ok;

    // hardware clear of listen mode on entry to on-line or active
    assign listen_clear = (mode_nxt != st_r.mode) &&
        ((mode_nxt == CAN_ONLINE) || (mode_nxt == CAN_ACTIVE));
    // loopback only with the transmitter off, so the bus stays quiet
    assign loop_on = cfg_loop && cfg_can_txoff;
    // a failure blocks the transmitter but leaves the stored bit alone
    assign can_tx_ok = !cfg_can_txoff && !can_failed;
    assign supply_need = (mode_nxt != CAN_OFFLINE) ||
        cfg_supply_keep;
    assign lin_tx_ok = lin_act_ok && !cfg_lin_txoff &&
        !lin_failed;
    assign lin_wake_ok = cfg_lin_wake && lin_bus_wake;

    ////////////////////////////////////////////////////////////////////////
    // registered values

    always_comb begin
        st_nxt = st_r;
        cfg_work = st_r.cfg;

        if (listen_clear) begin
            cfg_work[`PHYC_BIT_LISTEN] = 1'b0;
        end
        // a stored word lands last so it wins over the auto-clear
        if (word_store) begin
            cfg_work = word_cfg;
        end
        st_nxt.cfg = cfg_work;
        st_nxt.mode = mode_nxt;

        // extended timeout armed by wake-up, spent on reaching off-line
        if (mode_nxt == CAN_OFFLINE) begin
            st_nxt.ext = 1'b0;
        end
        if (wakeup_event) begin
            st_nxt.ext = 1'b1;
        end

        // readback shows contents from before this word's store
        st_nxt.rd_valid = word_hit;
        if (word_hit) begin
            st_nxt.rd_data = word_rdsel ? gp1_feedback :
                own_feedback;
        end

        // CAN data path
        st_nxt.tx_en = (mode_nxt == CAN_ACTIVE) && can_tx_ok;
        st_nxt.tx = can_transmit_pin;
        if (loop_on) begin
            st_nxt.rx = can_transmit_pin;
        end else begin
            st_nxt.rx = can_bus_rx;
        end

        // CAN supply and common-mode output
        st_nxt.supply_on = supply_need;
        st_nxt.split_oe_n = !cfg_common_mode;

        // LIN controls
        st_nxt.lin_act = lin_act_ok;
        st_nxt.lin_tx_en = lin_tx_ok;
        st_nxt.lin_wake = lin_wake_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r.cfg <= `PHYC_CFG_RESET;
            st_r.mode <= CAN_OFFLINE;
            st_r.ext <= 1'b0;
            st_r.rd_data <= `PHYC_WORD_ZERO;
            st_r.rd_valid <= 1'b0;
            st_r.rx <= 1'b1;
            st_r.tx <= 1'b1;
            st_r.tx_en <= 1'b0;
            st_r.supply_on <= 1'b0;
            st_r.split_oe_n <= 1'b1;
            st_r.lin_act <= 1'b0;
            st_r.lin_tx_en <= 1'b0;
            st_r.lin_wake <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign readback_valid = st_r.rd_valid;
    assign readback_word = st_r.rd_data;
    assign can_receive_pin = st_r.rx;
    assign can_bus_tx = st_r.tx;
    assign can_tx_enable = st_r.tx_en;
    assign can_mode = st_r.mode;
    assign can_supply_regulator_on = st_r.supply_on;
    assign can_common_mode_oe_n = st_r.split_oe_n;
    assign lin_active = st_r.lin_act;
    assign lin_tx_enable = st_r.lin_tx_en;
    assign lin_low_slope = cfg_lin_slope;
    assign lin_strong_drive = cfg_lin_drive;
    assign lin_wake_event = st_r.lin_wake;

endmodule : phyc_regs

// ===== core/phyc_params.svh
`ifndef PHYC_PARAMS_SVH
`define PHYC_PARAMS_SVH

// control word layout
`define PHYC_ADDR_HI 15
`define PHYC_ADDR_LO 14
`define PHYC_ADDR_PHY 2'h3
`define PHYC_BIT_RDSEL 13
`define PHYC_BIT_NOWRITE 12
`define PHYC_CFG_W 12
`define PHYC_WORD_W 16
`define PHYC_BIT_SUPPLY_KEEP 11
`define PHYC_BIT_LISTEN 10
`define PHYC_BIT_TOUT_LONG 9
`define PHYC_BIT_CAN_TXOFF 8
`define PHYC_BIT_LOOP 7
`define PHYC_BIT_CAN_ACT 6
`define PHYC_BIT_COMMON_MODE 5
`define PHYC_BIT_LIN_ACT 4
`define PHYC_BIT_LIN_SLOPE 3
`define PHYC_BIT_LIN_DRIVE 2
`define PHYC_BIT_LIN_WAKE 1
`define PHYC_BIT_LIN_TXOFF 0
`define PHYC_CFG_RESET 12'h000
`define PHYC_FB_FLAGS 2'h0
`define PHYC_WORD_ZERO 16'h0000

// bus-idle timing before off-line
`define PHYC_CLK_MHZ 100
`define PHYC_T_OFF_SHORT_US 200
`define PHYC_T_OFF_LONG_US 1000
`define PHYC_T_OFF_EXT_US 4000
`define PHYC_TMR_W 24
`define PHYC_TMR_ZERO 24'h000000
`define PHYC_TMR_ONE 24'h000001
`define PHYC_OFF_SHORT_CYC (`PHYC_T_OFF_SHORT_US * `PHYC_CLK_MHZ)
`define PHYC_OFF_LONG_CYC (`PHYC_T_OFF_LONG_US * `PHYC_CLK_MHZ)
`define PHYC_OFF_EXT_CYC (`PHYC_T_OFF_EXT_US * `PHYC_CLK_MHZ)

`endif

// ===== core/phyc_pkg.sv
`include "phyc_params.svh"

package phyc_pkg;

    typedef enum logic [1:0] {
        CAN_OFFLINE,
        CAN_ONLINE,
        CAN_LISTEN,
        CAN_ACTIVE
    } phyc_can_mode_t;

    typedef struct packed {
        logic [`PHYC_CFG_W-1:0] cfg;
        phyc_can_mode_t mode;
        logic ext;
        logic [`PHYC_WORD_W-1:0] rd_data;
        logic rd_valid;
        logic rx;
        logic tx;
        logic tx_en;
        logic supply_on;
        logic split_oe_n;
        logic lin_act;
        logic lin_tx_en;
        logic lin_wake;
    } phyc_state_t;

    typedef struct packed {
        logic [`PHYC_TMR_W-1:0] cnt;
    } phyc_tmr_state_t;

    typedef struct packed {
        logic failed;
        logic dis_prev;
    } phyc_fail_state_t;

endpackage : phyc_pkg

// ===== core/phyc_idle_timer.sv
`timescale 1ns/10ps
`include "phyc_params.svh"

module phyc_idle_timer
    import phyc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [`PHYC_TMR_W-1:0] limit,
    // result
    output logic expired
);

    phyc_tmr_state_t st_r;
    phyc_tmr_state_t st_nxt;

    // saturates at the limit so a late reader still sees expiry
    always_comb begin
        st_nxt = st_r;
        if (!run) begin
            st_nxt.cnt = `PHYC_TMR_ZERO;
        end else if (st_r.cnt < limit) begin
            st_nxt.cnt = st_r.cnt + `PHYC_TMR_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired = run && (st_r.cnt >= limit);

endmodule : phyc_idle_timer

// ===== core/phyc_tx_guard.sv
`timescale 1ns/10ps

module phyc_tx_guard
    import phyc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and software control
    input wire logic fail_event,
    input wire logic good_traffic,
    input wire logic sw_disable,
    // state
    output logic failed
);

    phyc_fail_state_t st_r;
    phyc_fail_state_t st_nxt;
    logic sw_release;

    // a set-then-clear of the disable bit is a manual recovery
    assign sw_release = st_r.dis_prev && !sw_disable;

    always_comb begin
        st_nxt = st_r;
        st_nxt.dis_prev = sw_disable;
        if (good_traffic || sw_release) begin
            st_nxt.failed = 1'b0;
        end
        // a new failure beats a recovery in the same cycle
        if (fail_event) begin
            st_nxt.failed = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign failed = st_r.failed;

endmodule : phyc_tx_guard

// ===== sim/phyc_host_model.sv
`timescale 1ns/10ps
`include "phyc_params.svh"

module phyc_host_model (
    // clock
    input wire logic clk,
    // word to the device
    output logic ctl_word_valid,
    output logic [`PHYC_WORD_W-1:0] ctl_word,
    // answer
    input wire logic readback_valid,
    input wire logic [`PHYC_WORD_W-1:0] readback_word
);
    initial begin
        ctl_word_valid = 1'b0;
        ctl_word = `PHYC_WORD_ZERO;
    end

    ////////////////////////////////////////
    // idle word is inverted so stale data never looks valid
    task automatic xfer(input logic [15:0] w, output logic [15:0] rd,
                        output logic got);
        @(negedge clk);
        ctl_word_valid = 1'b1;
        ctl_word = w;
        @(negedge clk);
        ctl_word_valid = 1'b0;
        ctl_word = ~w;
        got = readback_valid;
        rd = readback_word;
    endtask : xfer
endmodule : phyc_host_model

// ===== sim/phyc_regs_properties.sv
`timescale 1ns/10ps
`include "phyc_params.svh"

module phyc_regs_properties
    import phyc_pkg::*;
#(
    parameter logic [`PHYC_TMR_W-1:0] OFF_SHORT_CYC = 24'h000008
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic ctl_word_valid,
    input wire logic [`PHYC_WORD_W-1:0] ctl_word,
    input wire logic [`PHYC_WORD_W-1:0] gp1_feedback,
    input wire logic readback_valid,
    input wire logic [`PHYC_WORD_W-1:0] readback_word,
    // transceiver state
    input wire logic chip_normal_or_flash,
    input wire logic can_bus_activity,
    input wire logic can_if_fail,
    input wire logic can_good_traffic,
    input wire logic can_tx_enable,
    input wire phyc_can_mode_t can_mode,
    input wire logic can_common_mode_oe_n,
    input wire logic lin_active,
    input wire logic lin_low_slope,
    input wire logic lin_strong_drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic hit;
    logic [`PHYC_TMR_W-1:0] idle_r, idle_nxt;
    assign hit = ctl_word_valid && (ctl_word[15:14] == `PHYC_ADDR_PHY);

    // counts every idle cycle, so it never undercounts the design's timer
    always_comb begin
        idle_nxt = (&idle_r) ? idle_r : idle_r + `PHYC_TMR_ONE;
        if (!rst_n || can_bus_activity)
            idle_nxt = `PHYC_TMR_ZERO;
    end
    always_ff @(posedge clk) begin
        idle_r <= idle_nxt;
    end

    sequence s_store;
        hit && !ctl_word[12];
    endsequence
    sequence s_own_read;
        hit && !ctl_word[13];
    endsequence

    ////////////////////////////////////////
    chk_word_answer: assert property (hit |=> readback_valid)
        else $error("addressed word got no readback");
    chk_other_addr: assert property (!hit |=> !readback_valid)
        else $error("readback without addressed word");
    chk_gp_select: assert property (hit && ctl_word[13]
        |=> readback_word == $past(gp1_feedback))
        else $error("general purpose feedback wrong");
    chk_own_select: assert property (hit && !ctl_word[13]
        |=> readback_word[15:12] == 4'hc)
        else $error("own feedback header wrong");
    chk_read_only: assert property (hit && ctl_word[12]
        |=> $stable({lin_low_slope, lin_strong_drive}))
        else $error("read only word changed config");
    chk_slope_store: assert property (s_store
        |=> {lin_low_slope, lin_strong_drive} == $past(ctl_word[3:2]))
        else $error("lin slope or drive not stored");
    chk_feedback_hold: assert property (
        s_store ##1 !ctl_word_valid ##1 s_own_read
        |=> readback_word[11] == $past(ctl_word[11], 3) &&
            readback_word[9:0] == $past(ctl_word[9:0], 3))
        else $error("feedback differs from stored word");
    chk_split_drive: assert property (
        s_store ##1 !ctl_word_valid
        |=> can_common_mode_oe_n == !$past(ctl_word[5], 2))
        else $error("common mode output wrong");
    chk_can_gate: assert property (can_mode == CAN_ACTIVE
        |-> $past(chip_normal_or_flash))
        else $error("can active outside normal mode");
    chk_lin_gate: assert property (lin_active
        |-> $past(chip_normal_or_flash))
        else $error("lin active outside normal mode");
    chk_fail_off: assert property (can_if_fail
        ##1 !(can_good_traffic || ctl_word_valid) |=> !can_tx_enable)
        else $error("transmitter on after failure");
    chk_offline_wait: assert property (
        can_mode == CAN_OFFLINE && $past(can_mode) != CAN_OFFLINE
        |-> idle_r >= OFF_SHORT_CYC)
        else $error("off-line entered too early");
endmodule : phyc_regs_properties

bind phyc_regs phyc_regs_properties #(.OFF_SHORT_CYC(OFF_SHORT_CYC))
    i_phyc_regs_properties (.clk, .rst_n, .ctl_word_valid, .ctl_word,
    .gp1_feedback, .readback_valid, .readback_word, .chip_normal_or_flash,
    .can_bus_activity, .can_if_fail, .can_good_traffic, .can_tx_enable,
    .can_mode, .can_common_mode_oe_n, .lin_active, .lin_low_slope,
    .lin_strong_drive);

// ===== sim/test_phy_layer_control_regs.sv
`timescale 1ns/10ps
`include "phyc_params.svh"

module test_phy_layer_control_regs;
    import phyc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctl_word_valid, readback_valid, can_receive_pin, can_bus_tx;
    logic [15:0] ctl_word, readback_word, w, gp1_feedback = 16'h0000;
    logic chip_normal_or_flash = 1'b0, wakeup_event = 1'b0, e;
    logic can_transmit_pin = 1'b1, can_bus_rx = 1'b1, can_bus_activity = 1'b0;
    logic can_if_fail = 1'b0, can_good_traffic = 1'b0, lin_bus_wake = 1'b0;
    logic lin_if_fail = 1'b0, lin_good_traffic = 1'b0;
    logic can_tx_enable, can_supply_regulator_on, can_common_mode_oe_n;
    logic lin_active, lin_tx_enable, lin_low_slope, lin_strong_drive;
    logic lin_wake_event;
    phyc_can_mode_t can_mode;
    logic [11:0] cfg = 12'h000;
    int mismatches = 0, check_count = 0, seed = 21, n;
    int lim[3] = '{8, 16, 32};

    always #5 clk = ~clk;

    phyc_regs #(.OFF_SHORT_CYC(24'h000008), .OFF_LONG_CYC(24'h000010),
        .OFF_EXT_CYC(24'h000020)) i_phyc_regs (.clk, .rst_n,
        .ctl_word_valid, .ctl_word, .gp1_feedback, .readback_valid,
        .readback_word, .chip_normal_or_flash, .wakeup_event,
        .can_transmit_pin, .can_receive_pin, .can_bus_rx, .can_bus_activity,
        .can_if_fail, .can_good_traffic, .can_bus_tx, .can_tx_enable,
        .can_mode, .can_supply_regulator_on, .can_common_mode_oe_n,
        .lin_bus_wake, .lin_if_fail, .lin_good_traffic, .lin_active,
        .lin_tx_enable, .lin_low_slope, .lin_strong_drive, .lin_wake_event);
    phyc_host_model i_phyc_host_model (.clk, .ctl_word_valid, .ctl_word,
        .readback_valid, .readback_word);

    ////////////////////////////////////////
    task automatic cmp(input logic [15:0] g, input logic [15:0] x);
        check_count++;
        if (g !== x) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : cmp

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse

    // model: cfg holds the stored word, readback shows it before the write
    task automatic word(input logic [15:0] v);
        logic [15:0] rd, x;
        logic got;
        x = v[13] ? gp1_feedback : {4'hc, cfg};
        i_phyc_host_model.xfer(v, rd, got);
        cmp(16'(got), 16'(v[15:14] == 2'h3));
        if (v[15:14] == 2'h3) begin
            cmp(rd, x);
            if (!v[12])
                cfg = v[11:0];
        end
    endtask : word

    task automatic wait_mode(input phyc_can_mode_t m);
        n = 0;
        while (can_mode !== m && n < 50) begin
            @(negedge clk);
            n++;
        end
        cmp(16'(can_mode), 16'(m));
        if (n >= 50)
            summarize;
    endtask : wait_mode

    task automatic statics;
        repeat (2) @(negedge clk);
        e = (cfg[7] & cfg[8]) ? can_transmit_pin : can_bus_rx;
        cmp(16'({lin_low_slope, lin_strong_drive}), 16'(cfg[3:2]));
        cmp(16'(can_common_mode_oe_n), 16'(!cfg[5]));
        cmp(16'(can_supply_regulator_on), 16'(cfg[11]));
        cmp(16'(can_receive_pin), 16'(e));
        cmp(16'(can_bus_tx), 16'(can_transmit_pin));
        cmp(16'(lin_tx_enable), 16'h0000);
        pulse(lin_bus_wake);
        cmp(16'(lin_wake_event), 16'(cfg[1]));
    endtask : statics

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 24; i++) begin
            can_transmit_pin = 1'($random(seed));
            can_bus_rx = 1'($random(seed));
            gp1_feedback = 16'($random(seed));
            w = 16'($random(seed));
            if (i % 6 != 5)
                w[15:14] = 2'h3;
            word(w);
            statics;
        end
        $display("done: control words");
        word(16'hc450);
        can_bus_activity = 1'b1;
        wait_mode(CAN_LISTEN);
        chip_normal_or_flash = 1'b1;
        wait_mode(CAN_ACTIVE);
        cfg[10] = 1'b0;
        word(16'hd000);
        cmp(16'(lin_active), 16'h0001);
        cmp(16'(can_tx_enable), 16'h0001);
        cmp(16'(lin_tx_enable), 16'h0001);
        lin_if_fail = 1'b1;
        pulse(can_if_fail);
        lin_if_fail = 1'b0;
        repeat (2) @(negedge clk);
        cmp(16'(can_tx_enable), 16'h0000);
        cmp(16'(lin_tx_enable), 16'h0000);
        lin_good_traffic = 1'b1;
        pulse(can_good_traffic);
        lin_good_traffic = 1'b0;
        repeat (2) @(negedge clk);
        cmp(16'(can_tx_enable), 16'h0001);
        cmp(16'(lin_tx_enable), 16'h0001);
        pulse(can_if_fail);
        word(16'hc150);
        word(16'hc050);
        repeat (2) @(negedge clk);
        cmp(16'(can_tx_enable), 16'h0001);
        word(16'hc051);
        repeat (2) @(negedge clk);
        cmp(16'(lin_tx_enable), 16'h0000);
        chip_normal_or_flash = 1'b0;
        wait_mode(CAN_ONLINE);
        cmp(16'(lin_active), 16'h0000);
        $display("done: transmitter path");
        for (int k = 0; k < 3; k++) begin
            if (k > 0) begin
                word(k == 1 ? 16'hc200 : 16'hc000);
                if (k == 2)
                    pulse(wakeup_event);
                can_bus_activity = 1'b1;
                wait_mode(CAN_ONLINE);
            end
            can_bus_activity = 1'b0;
            n = 0;
            while (can_mode !== CAN_OFFLINE && n < 200) begin
                @(negedge clk);
                n++;
            end
            cmp(16'(n >= lim[k] && n <= lim[k] + 3), 16'h0001);
            if (n >= 200)
                summarize;
        end
        $display("done: idle timeout");
        summarize;
    end
endmodule : test_phy_layer_control_regs
